// file: rtl/ifd_decoder.sv
// Module: instruction field decoder with integer add execution
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Word is four 8-bit fields, opcode on top
// - Opcode bit0 picks relative or absolute address
// - Opcode bit0 picks register or immediate operand
// - Register numbers at 23..16, 15..8, 7..0
// - Middle field names special register when asked
// - Jump address: high byte 23..16, low 7..0
// - 16-bit constant: high 23..16, low 7..0
// - Trap vector taken from bits 23..16
// - Low byte is register or constant per bit0
// - Convert control: unsigned, rounding, destination_register, source
// - Classify/square root use only source format
// - Add opcodes 14/15 write first source plus second source (14) or zero-extended 8-bit constant (15)
// - Add sets overflow, negative, zero, carry
// - Overflow is carry-in xor carry-out of top
// - Freeze bit holds flags except explicit move
module ifd_decoder (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                instr_valid,   // Fetch presents a word
  input  wire logic [31:0]         instr_word,    // Instruction word
  input  wire logic [31:0]         first_source_value,    // Register file read A
  input  wire logic [31:0]         second_source_value,    // Register file read B
  input  wire logic                status_freeze_bit, // Flag freeze
  input  wire logic                flags_wr,      // Move to special reg
  input  wire ifd_pkg::ifd_flags_t flags_wr_data, // Value for that move
  output ifd_pkg::ifd_fields_t     fields_q,      // Decoded fields
  output ifd_pkg::ifd_cvt_t        cvt_q,         // Conversion controls
  output logic [1:0]               fmt_q,         // Class/square_root_op format
  output logic                     decode_valid_q,// Fields are fresh
  output logic                     wr_en_q,       // Write destination
  output logic [7:0]               wr_reg_q,      // Destination number
  output logic [31:0]              wr_data_q,     // Destination value
  output ifd_pkg::ifd_flags_t      flags_q        // Arithmetic flags
);

  ifd_pkg::ifd_fields_t fields_d;  // Combinational field split
  ifd_pkg::ifd_cvt_t    cvt_d;     // Combinational conversion split
  logic [31:0]          opb;       // Second source after selection
  logic [31:0]          sum;       // Adder result
  ifd_pkg::ifd_flags_t  add_flags; // Flags from the adder
  logic                 is_add;    // Valid add instruction this cycle

  // Field split; unused fields are just not consumed
  always_comb begin
    fields_d.opcode        = instr_word[ifd_pkg::OPC_LSB +: 8];
    fields_d.absolute_sel  = instr_word[ifd_pkg::OPC_LSB];
    fields_d.immediate_sel = instr_word[ifd_pkg::OPC_LSB];
    fields_d.destination_register_reg      = instr_word[ifd_pkg::DESTINATION_REGISTER_LSB +: 8];
    fields_d.first_source_reg      = instr_word[ifd_pkg::FIRST_SOURCE_LSB +: 8];
    fields_d.second_source_reg      = instr_word[ifd_pkg::SECOND_SOURCE_LSB +: 8];
    fields_d.special_reg   = instr_word[ifd_pkg::FIRST_SOURCE_LSB +: 8];
    fields_d.trap_vector   = instr_word[ifd_pkg::DESTINATION_REGISTER_LSB +: 8];
    fields_d.const8        = instr_word[ifd_pkg::SECOND_SOURCE_LSB +: 8];
    // Constant and address share one layout: high byte, then low byte
    fields_d.const16   = {instr_word[ifd_pkg::DESTINATION_REGISTER_LSB +: 8],
                          instr_word[ifd_pkg::SECOND_SOURCE_LSB +: 8]};
    fields_d.word_addr = {instr_word[ifd_pkg::DESTINATION_REGISTER_LSB +: 8],
                          instr_word[ifd_pkg::SECOND_SOURCE_LSB +: 8]};
  end

  // Conversion control subfields out of the low byte
  always_comb begin
    cvt_d.int_unsigned  = instr_word[ifd_pkg::UI_POS];
    cvt_d.rounding_mode = instr_word[ifd_pkg::RND_LSB +: 3];
    cvt_d.destination_register_format   = instr_word[ifd_pkg::FD_LSB +: 2];
    cvt_d.source_format = instr_word[ifd_pkg::FS_LSB +: 2];
  end

  // Add is recognised on either opcode; bit0 then selects the operand
  // Comparing bits 7..1 covers both forms with one compare
  assign is_add = instr_valid &&
                  (fields_d.opcode[7:1] ==
                   ifd_pkg::OPC_ADD_REG[7:1]);

  // Immediate form zero-extends the 8-bit constant
  assign opb = fields_d.immediate_sel ? {24'h000000, fields_d.const8}
                                      : second_source_value;

  // Shared adder; flags come from the add itself
  ifd_adder #(
    .W (32)
  ) u_adder (
    .a     (first_source_value),
    .b     (opb),
    .sum   (sum),
    .flags (add_flags)
  );

  // Register decoded fields one cycle after the word is presented
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fields_q       <= '0;
      cvt_q          <= '0;
      fmt_q          <= 2'h0;
      decode_valid_q <= 1'b0;
    end else begin
      decode_valid_q <= instr_valid;
      if (instr_valid) begin
        fields_q <= fields_d;
        cvt_q    <= cvt_d;
        // Only the source format counts; the rest is reserved
        fmt_q    <= cvt_d.source_format;
      end
    end
  end

  // Destination write port for the add
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_en_q   <= 1'b0;
      wr_reg_q  <= 8'h00;
      wr_data_q <= ifd_pkg::WORD_RST;
    end else begin
      wr_en_q <= is_add;
      if (is_add) begin
        wr_reg_q  <= fields_d.destination_register_reg;
        wr_data_q <= sum;
      end
    end
  end

  // Flags: explicit move always wins; freeze blocks instruction updates
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= ifd_pkg::FLAGS_RST;
    end else if (flags_wr) begin
      flags_q <= flags_wr_data;
    end else if (is_add && !status_freeze_bit) begin
      flags_q <= add_flags;
    end
  end

  // Assertions
  property p_add_writes_sum;
    @(posedge clk) disable iff (!reset_n)
      is_add |=> wr_en_q && wr_data_q == $past(first_source_value) + $past(opb);
  endproperty
  a_add_writes_sum: assert property (p_add_writes_sum)
    else $error("add result wrong");

  property p_imm_zero_ext;
    @(posedge clk) disable iff (!reset_n)
      is_add && instr_word[24] |=>
        wr_data_q == $past(first_source_value) + {24'h000000, $past(instr_word[7:0])};
  endproperty
  a_imm_zero_ext: assert property (p_imm_zero_ext)
    else $error("immediate not zero-extended");

  property p_reg_fields;
    @(posedge clk) disable iff (!reset_n)
      instr_valid |=> fields_q.destination_register_reg == $past(instr_word[23:16]) &&
        fields_q.first_source_reg == $past(instr_word[15:8]) &&
        fields_q.second_source_reg == $past(instr_word[7:0]);
  endproperty
  a_reg_fields: assert property (p_reg_fields)
    else $error("register fields wrong");

  property p_const16;
    @(posedge clk) disable iff (!reset_n)
      instr_valid |=> fields_q.const16 ==
        {$past(instr_word[23:16]), $past(instr_word[7:0])};
  endproperty
  a_const16: assert property (p_const16)
    else $error("16-bit constant wrong");

  property p_addr_sel;
    @(posedge clk) disable iff (!reset_n)
      instr_valid |=> fields_q.absolute_sel == $past(instr_word[24]) &&
        fields_q.word_addr == {$past(instr_word[23:16]),
                               $past(instr_word[7:0])};
  endproperty
  a_addr_sel: assert property (p_addr_sel)
    else $error("address fields wrong");

  property p_zero_flag;
    @(posedge clk) disable iff (!reset_n)
      is_add && !status_freeze_bit && !flags_wr |=>
        flags_q.z == (wr_data_q == 32'h0000_0000) &&
        flags_q.n == wr_data_q[31];
  endproperty
  a_zero_flag: assert property (p_zero_flag)
    else $error("zero or negative flag wrong");

  property p_overflow;
    @(posedge clk) disable iff (!reset_n)
      is_add && !status_freeze_bit && !flags_wr |=>
        flags_q.v == (($past(first_source_value[31]) == $past(opb[31])) &&
                      (wr_data_q[31] != $past(first_source_value[31])));
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow flag wrong");

  property p_freeze;
    @(posedge clk) disable iff (!reset_n)
      status_freeze_bit && !flags_wr |=> $stable(flags_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("flags changed while frozen");

  property p_trap_vec;
    @(posedge clk) disable iff (!reset_n)
      instr_valid |=> fields_q.trap_vector == $past(instr_word[23:16]) &&
        fmt_q == $past(instr_word[1:0]);
  endproperty
  a_trap_vec: assert property (p_trap_vec)
    else $error("trap vector or format wrong");

  // Main scenarios
  c_add_reg: cover property (@(posedge clk) is_add && !instr_word[24]);
  c_add_imm: cover property (@(posedge clk) is_add && instr_word[24]);
  c_frozen:  cover property (@(posedge clk) is_add && status_freeze_bit);
  c_ovf:     cover property (@(posedge clk) is_add && add_flags.v);

endmodule
`default_nettype wire

// file: rtl/ifd_pkg.sv
// Package: field layout, opcodes and reset values of the instruction decoder
package ifd_pkg;

  // Word and field geometry
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned FIELD_W    = 8;
  localparam int unsigned OPC_LSB    = 24;
  localparam int unsigned DESTINATION_REGISTER_LSB   = 16;
  localparam int unsigned FIRST_SOURCE_LSB   = 8;
  localparam int unsigned SECOND_SOURCE_LSB   = 0;

  // Conversion control subfield positions within bits 7..0
  localparam int unsigned UI_POS     = 7;
  localparam int unsigned RND_LSB    = 4;
  localparam int unsigned FD_LSB     = 2;
  localparam int unsigned FS_LSB     = 0;

  // Integer add opcodes (register and immediate forms)
  localparam logic [7:0] OPC_ADD_REG = 8'h14;
  localparam logic [7:0] OPC_ADD_IMM = 8'h15;

  // Reset values
  localparam logic [31:0] WORD_RST   = 32'h0000_0000;
  localparam logic [3:0]  FLAGS_RST  = 4'h0;

  // Arithmetic status flags
  typedef struct packed {
    logic v;
    logic n;
    logic z;
    logic c;
  } ifd_flags_t;

  // Conversion controls
  typedef struct packed {
    logic       int_unsigned;
    logic [2:0] rounding_mode;
    logic [1:0] destination_register_format;
    logic [1:0] source_format;
  } ifd_cvt_t;

  // Decoded operand fields
  typedef struct packed {
    logic [7:0]  opcode;
    logic        absolute_sel;
    logic        immediate_sel;
    logic [7:0]  destination_register_reg;
    logic [7:0]  first_source_reg;
    logic [7:0]  second_source_reg;
    logic [7:0]  special_reg;
    logic [7:0]  trap_vector;
    logic [7:0]  const8;
    logic [15:0] const16;
    logic [15:0] word_addr;
  } ifd_fields_t;

endpackage

// file: rtl/ifd_adder.sv
// Module: 32-bit adder that yields the four arithmetic flags
`timescale 1ns/1ps
`default_nettype none

module ifd_adder #(
  parameter int unsigned W = 32
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  output logic      [W-1:0] sum,
  output ifd_pkg::ifd_flags_t flags
);

  logic [W-1:0] low;    // Full sum: bits below the top one added, top bit is a, b and c_msb xored
  logic         c_msb;  // Carry into the top bit
  logic         c_out;  // Carry out of the top bit

  // Split add so the carry into the top bit is visible
  always_comb begin
    {c_msb, low[W-2:0]} = {1'b0, a[W-2:0]} + {1'b0, b[W-2:0]};
    low[W-1] = a[W-1] ^ b[W-1] ^ c_msb;
    c_out    = (a[W-1] & b[W-1]) | (c_msb & (a[W-1] ^ b[W-1]));
    sum      = low;
    flags.v  = c_msb ^ c_out;
    flags.n  = low[W-1];
    flags.z  = (low == '0);
    flags.c  = c_out;
  end

endmodule
`default_nettype wire

// file: testbench/ifd_regfile_model.sv
// Register file model that feeds both source operands to the decoder
`timescale 1ns/1ps
`default_nettype none

module ifd_regfile_model (
  input  wire logic        instr_valid, // Fetch presents a word
  input  wire logic [31:0] instr_word,  // Word whose fields select registers
  output logic      [31:0] first_source_value,  // First source read
  output logic      [31:0] second_source_value   // Second source read
);
  // Register r holds r in every byte; when no word is offered the
  // reads show the inverse so a stale operand is never mistaken as good
  always_comb begin
    first_source_value = {4{instr_word[15:8]}};
    second_source_value = {4{instr_word[7:0]}};
    if (!instr_valid) begin
      first_source_value = ~first_source_value;
      second_source_value = ~second_source_value;
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb_ifd_decoder.sv
// Testbench for the instruction field decoder with integer add
`timescale 1ns/1ps
`default_nettype none

module tb_ifd_decoder;
  logic                clk;
  logic                reset_n;
  logic                instr_valid;
  logic [31:0]         instr_word;
  logic [31:0]         first_source_value;
  logic [31:0]         second_source_value;
  logic                status_freeze_bit;
  logic                flags_wr;
  ifd_pkg::ifd_flags_t flags_wr_data;
  ifd_pkg::ifd_fields_t fields_q;
  ifd_pkg::ifd_cvt_t   cvt_q;
  logic [1:0]          fmt_q;
  logic                decode_valid_q;
  logic                wr_en_q;
  logic [7:0]          wr_reg_q;
  logic [31:0]         wr_data_q;
  ifd_pkg::ifd_flags_t flags_q;
  ifd_pkg::ifd_flags_t exp_flags; // Flags the bench expects to stand
  int                  num_errors;
  int                  n_checks;
  // Non-add words carry distinct non-zero bytes in every field
  logic [31:0] words [7] = '{32'h22a1b2c3, 32'h235a0f6e, 32'h14037f01,
    32'h1504ff01, 32'h15050080, 32'h14068080, 32'h15071200};

  ifd_decoder u_ifd_decoder (.clk(clk), .reset_n(reset_n),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .first_source_value(first_source_value), .second_source_value(second_source_value),
    .status_freeze_bit(status_freeze_bit), .flags_wr(flags_wr),
    .flags_wr_data(flags_wr_data), .fields_q(fields_q), .cvt_q(cvt_q),
    .fmt_q(fmt_q), .decode_valid_q(decode_valid_q), .wr_en_q(wr_en_q),
    .wr_reg_q(wr_reg_q), .wr_data_q(wr_data_q), .flags_q(flags_q));

  ifd_regfile_model u_ifd_regfile_model (.instr_valid(instr_valid),
    .instr_word(instr_word), .first_source_value(first_source_value),
    .second_source_value(second_source_value));

  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // One comparison; four-state equality so unknowns never match
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Every output must be back at its reset value
  task automatic chk_rst(input string nm);
    chk({nm, " fields"}, 32'h1, 32'(fields_q == '0));
    chk({nm, " cvt_fmt"}, 32'h0, {22'h0, cvt_q, fmt_q});
    chk({nm, " pulses"}, 32'h0, {30'h0, decode_valid_q, wr_en_q});
    chk({nm, " wr_reg"}, 32'h0, 32'(wr_reg_q));
    chk({nm, " wr_data"}, ifd_pkg::WORD_RST, wr_data_q);
    chk({nm, " flags"}, 32'(ifd_pkg::FLAGS_RST), 32'(flags_q));
  endtask

  // Offer one word at an edge, check the outputs one edge later, wr_reg_q and wr_data_q for adds only.
  // The prediction is made after the first edge so that a freeze
  // level driven at the edge before is already seen here.
  task automatic exec(input logic [31:0] w);
    logic [7:0]  op;
    logic [31:0] a;
    logic [31:0] b;
    logic [32:0] s;
    logic [31:0] c16;
    logic        add;
    @(posedge clk);
    op  = w[31:24];
    a   = {4{w[15:8]}};
    b   = op[0] ? {24'h0, w[7:0]} : {4{w[7:0]}};
    s   = {1'b0, a} + {1'b0, b};
    c16 = {16'h0, w[23:16], w[7:0]};
    add = (op == ifd_pkg::OPC_ADD_REG) || (op == ifd_pkg::OPC_ADD_IMM);
    // Overflow: operands agree in sign but the sum does not
    if (add && !status_freeze_bit)
      exp_flags = {(a[31] == b[31]) && (s[31] != a[31]), s[31],
                   s[31:0] == 32'h0, s[32]};
    instr_valid <= 1'b1;
    instr_word  <= w;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    chk("decode_valid", 32'h1, 32'(decode_valid_q));
    chk("opcode", 32'(op), 32'(fields_q.opcode));
    chk("abs_sel", 32'(op[0]), 32'(fields_q.absolute_sel));
    chk("imm_sel", 32'(op[0]), 32'(fields_q.immediate_sel));
    chk("destination_register_reg", 32'(w[23:16]), 32'(fields_q.destination_register_reg));
    chk("first_source_reg", 32'(w[15:8]), 32'(fields_q.first_source_reg));
    chk("second_source_reg", 32'(w[7:0]), 32'(fields_q.second_source_reg));
    chk("special_reg", 32'(w[15:8]), 32'(fields_q.special_reg));
    chk("trap_vector", 32'(w[23:16]), 32'(fields_q.trap_vector));
    chk("const8", 32'(w[7:0]), 32'(fields_q.const8));
    chk("const16", c16, 32'(fields_q.const16));
    chk("word_addr", c16, 32'(fields_q.word_addr));
    chk("cvt", 32'(w[7:0]), 32'(cvt_q));
    chk("fmt", 32'(w[1:0]), 32'(fmt_q));
    chk("wr_en", 32'(add), 32'(wr_en_q));
    if (add) begin
      chk("wr_reg", 32'(w[23:16]), 32'(wr_reg_q));
      chk("wr_data", s[31:0], wr_data_q);
    end
    chk("flags", 32'(exp_flags), 32'(flags_q));
  endtask

  // Closing report, the single place the run ends
  task automatic print_verdict;
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    num_errors = 0;
    n_checks = 0;
    exp_flags = ifd_pkg::FLAGS_RST;
    reset_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 32'h0;
    status_freeze_bit = 1'b0;
    flags_wr = 1'b0;
    flags_wr_data = 4'h0;
    // Reset held for five edges, released by the fifth
    repeat (4) @(posedge clk);
    #1;
    chk_rst("rst");
    @(posedge clk);
    reset_n <= 1'b1;
    foreach (words[i]) exec(words[i]);
    // Back to back adds each write once, one cycle apart
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word  <= 32'h14100102;
    @(posedge clk);
    instr_word  <= 32'h15110205;
    #1;
    chk("b2b en0", 32'h1, 32'(wr_en_q));
    chk("b2b data0", 32'h03030303, wr_data_q);
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    chk("b2b en1", 32'h1, 32'(wr_en_q));
    chk("b2b data1", 32'h02020207, wr_data_q);
    chk("b2b reg1", 32'h11, 32'(wr_reg_q));
    @(posedge clk);
    #1;
    chk("b2b wr_en", 32'h0, 32'(wr_en_q));
    chk("b2b valid", 32'h0, 32'(decode_valid_q));
    chk("b2b flags", 32'h0, 32'(flags_q));
    exp_flags = 4'h0;
    // Freeze: add still writes but flags hold; explicit move loads
    @(posedge clk);
    status_freeze_bit <= 1'b1;
    exec(32'h14207f01);
    @(posedge clk);
    flags_wr      <= 1'b1;
    flags_wr_data <= 4'h5;
    @(posedge clk);
    flags_wr <= 1'b0;
    #1;
    chk("move frozen", 32'h5, 32'(flags_q));
    // Move in the same cycle as an unfrozen add wins; the add writes
    @(posedge clk);
    status_freeze_bit <= 1'b0;
    instr_valid       <= 1'b1;
    instr_word        <= 32'h1421ff01;
    flags_wr          <= 1'b1;
    flags_wr_data     <= 4'ha;
    @(posedge clk);
    instr_valid <= 1'b0;
    flags_wr    <= 1'b0;
    #1;
    chk("move wins", 32'ha, 32'(flags_q));
    chk("move add", 32'h01010100, wr_data_q);
    // Reset in mid-run clears every output at once, then work resumes
    @(posedge clk);
    reset_n <= 1'b0;
    #1;
    chk_rst("mid rst");
    @(posedge clk);
    reset_n <= 1'b1;
    exp_flags = ifd_pkg::FLAGS_RST;
    exec(32'h14307f01);
    print_verdict();
  end
endmodule
`default_nettype wire
